// file: src/tmc_div_if.sv
// Request and answer lines between the command block and its divider.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface tmc_div_if;
  logic start;
  logic [22:0] dividend;
  logic [15:0] divisor;
  logic busy;
  logic done;
  logic [22:0] quotient;
  modport requester (output start, output dividend, output divisor,
                     input busy, input done, input quotient);
  modport divider (input start, input dividend, input divisor,
                   output busy, output done, output quotient);
endinterface
`default_nettype wire

// file: src/tmc_divider.sv
// Restoring unsigned divider, one quotient bit per clock.
// Assumes start is only raised while busy is low.
`timescale 1ns/1ps
`default_nettype none
module tmc_divider (
  input wire logic clock,
  input wire logic rst,
  tmc_div_if.divider div
);
  logic [15:0] rem;
  logic [4:0] steps;
  logic [17:0] diff;

  assign diff = {1'b0, rem, div.quotient[22]} - {2'h0, div.divisor};

  always_ff @(posedge clock) begin
    if (rst) begin
      rem <= 16'h0000;
      steps <= 5'h00;
      div.busy <= 1'b0;
      div.done <= 1'b0;
      div.quotient <= 23'h000000;
    end else begin
      div.done <= 1'b0;
      if (div.start && !div.busy) begin
        rem <= 16'h0000;
        div.quotient <= div.dividend;
        steps <= tmc_pkg::DIV_STEPS;
        div.busy <= 1'b1;
      end else if (div.busy) begin
        // Zero divisor yields all ones, which the caller clamps
        if (!diff[17]) begin
          rem <= diff[15:0];
          div.quotient <= {div.quotient[21:0], 1'b1};
        end else begin
          rem <= {rem[14:0], div.quotient[22]};
          div.quotient <= {div.quotient[21:0], 1'b0};
        end
        steps <= steps - 5'h01;
        if (steps == 5'h01) begin
          div.busy <= 1'b0;
          div.done <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: src/tmc_pkg.sv
// Constants, field layout and types of the template record command block.
// Assumes a single clock domain; shared by all block files.
package tmc_pkg;
  localparam logic [7:0] HASH_CHAR = 8'h23;
  localparam logic [7:0] LEN_DIGITS_CHAR = 8'h33;
  localparam logic [7:0] LEN_CHAR_0 = 8'h35;
  localparam logic [7:0] LEN_CHAR_1 = 8'h34;
  localparam logic [7:0] LEN_CHAR_2 = 8'h38;
  localparam int REC_LEN = 548;
  localparam int MEM_BYTES = 54800;
  localparam logic [9:0] REC_LAST = 10'h223;
  localparam logic [2:0] HDR_LAST = 3'h4;
  localparam logic [9:0] LEN_LAST = 10'h002;
  localparam logic [7:0] PACKAGE_TYPE = 8'h03;
  localparam logic [7:0] SLOT_MIN = 8'h01;
  localparam logic [7:0] SLOT_MAX = 8'h64;
  localparam logic [9:0] OFS_TYPE = 10'h000;
  localparam logic [9:0] OFS_SLOT = 10'h001;
  localparam logic [9:0] OFS_POS_LO = 10'h003;
  localparam logic [9:0] OFS_LABEL = 10'h004;
  localparam logic [9:0] OFS_LABEL_END = 10'h02a;
  localparam logic [9:0] OFS_RSV = 10'h02b;
  localparam logic [9:0] OFS_SUM = 10'h02c;
  localparam logic [9:0] OFS_SUM_END = 10'h02f;
  localparam logic [9:0] OFS_DATA = 10'h030;
  localparam logic [15:0] POS_MIN = 16'hfed4;
  localparam logic [15:0] POS_MAX = 16'h012c;
  localparam logic [15:0] POINT_MIN = 16'hff9c;
  localparam logic [15:0] POINT_MAX = 16'h0064;
  localparam logic [6:0] DUTY_MIN = 7'h01;
  localparam logic [6:0] DUTY_MAX = 7'h63;
  localparam logic [6:0] PERCENT = 7'h64;
  localparam logic [4:0] DIV_STEPS = 5'h17;
  localparam logic MODE_NORMAL = 1'b0;
  localparam logic MODE_AUTO = 1'b1;
  localparam logic [1:0] MEAS_CH_RST = 2'h1;
  localparam logic [6:0] MAX_SEL_RST = 7'h01;
  localparam logic [6:0] MIN_SEL_RST = 7'h02;
  localparam logic [1:0] AUTO_CH_RST = 2'h1;
  localparam logic RUN_RST = 1'b1;

  typedef enum logic [3:0] {
    CMD_UPLOAD = 4'h0,
    CMD_DOWNLOAD = 4'h1,
    CMD_SET_MAX = 4'h2,
    CMD_SET_MIN = 4'h3,
    CMD_SET_MODE = 4'h4,
    CMD_SET_SOURCE = 4'h5,
    CMD_SET_MEAS_CH = 4'h6,
    CMD_RUN = 4'h7,
    CMD_STOP = 4'h8,
    CMD_DUTY = 4'h9
  } tmc_cmd_type;

  typedef enum logic [1:0] {
    SRC_STORED = 2'h0,
    SRC_REFERENCE_WAVE_A = 2'h1,
    SRC_REFERENCE_WAVE_B = 2'h2
  } tmc_src_type;

  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_HASH = 10'h002,
    ST_NDIG = 10'h004,
    ST_LEN = 10'h008,
    ST_LOAD = 10'h010,
    ST_CHECK = 10'h020,
    ST_COPY = 10'h040,
    ST_SEND_HDR = 10'h080,
    ST_SEND_BODY = 10'h100,
    ST_DRAIN = 10'h200
  } tmc_state_type;
endpackage

// file: src/tmc_template_cmd.sv
// Template record transfer, boundary selection, measurement and run control.
// Assumes decoded commands arrive on cmd_*, record bytes on rx_*/tx_* streams.
`timescale 1ns/1ps
`default_nettype none
module tmc_template_cmd (
  input wire logic clock,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire tmc_pkg::tmc_cmd_type cmd_code,
  input wire logic [7:0] cmd_arg,
  output logic cmd_ready,
  output logic cmd_done,
  output logic cmd_refused,
  input wire logic passfail_enable,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  output logic upload_stored,
  output logic upload_discarded,
  output logic [6:0] max_template,
  output logic [6:0] min_template,
  output logic template_mode,
  output logic [1:0] auto_source_channel,
  output tmc_pkg::tmc_src_type normal_source,
  output logic [1:0] measure_channel_select,
  input wire logic [1:0][15:0] ch_high,
  input wire logic [1:0][15:0] ch_low,
  input wire logic [1:0][15:0] ch_max,
  input wire logic [1:0][15:0] ch_min,
  input wire logic [1:0][15:0] ch_pos_width,
  input wire logic [1:0][15:0] ch_period,
  output logic [15:0] amplitude,
  output logic [15:0] peak_to_peak,
  output logic [6:0] duty_ratio,
  output logic duty_ready,
  input wire logic trigger_qualified,
  output logic running,
  output logic acquire_start
);
  tmc_pkg::tmc_state_type state;
  logic [9:0] cnt;
  logic [6:0] slot_sel;
  logic [15:0] base;
  logic [15:0] mem_addr;
  logic [7:0] store_mem [0:tmc_pkg::MEM_BYTES-1];
  logic [7:0] stage [0:tmc_pkg::REC_LEN-1];
  logic rx_fire;
  logic tx_load;
  logic cmd_take;
  logic legal;
  logic slot_ok;
  logic [7:0] exp_char;
  logic hdr_abort;
  logic rec_ok;
  logic bad;
  logic zero_seen;
  logic [7:0] hold;
  logic [31:0] rx_sum;
  logic [31:0] data_sum;
  logic [15:0] pair;
  logic ch_idx;
  tmc_div_if div_bus ();

  tmc_divider divider (
    .clock(clock),
    .rst(rst),
    .div(div_bus.divider)
  );

  assign rx_fire = rx_valid && rx_ready;
  assign tx_load = !tx_valid || tx_ready;
  assign cmd_ready = (state == tmc_pkg::ST_IDLE) && !div_bus.busy;
  assign cmd_take = cmd_valid && cmd_ready;
  assign rx_ready = (state == tmc_pkg::ST_HASH) || (state == tmc_pkg::ST_NDIG) ||
                    (state == tmc_pkg::ST_LEN) || (state == tmc_pkg::ST_LOAD);
  assign slot_ok = (cmd_arg >= tmc_pkg::SLOT_MIN) && (cmd_arg <= tmc_pkg::SLOT_MAX);
  assign base = 16'((slot_sel - 7'h01) * tmc_pkg::REC_LEN);
  assign mem_addr = base + 16'(cnt);
  assign pair = {hold, rx_data};
  assign ch_idx = (measure_channel_select == 2'h2);

  always_comb begin
    case (cnt[1:0])
      2'h0: exp_char = tmc_pkg::LEN_CHAR_0;
      2'h1: exp_char = tmc_pkg::LEN_CHAR_1;
      default: exp_char = tmc_pkg::LEN_CHAR_2;
    endcase
  end

  // Framing faults lose the length, so they end the transfer at once
  always_comb begin
    hdr_abort = 1'b0;
    if (rx_fire) begin
      if (state == tmc_pkg::ST_HASH && rx_data != tmc_pkg::HASH_CHAR) begin
        hdr_abort = 1'b1;
      end
      if (state == tmc_pkg::ST_NDIG && rx_data != tmc_pkg::LEN_DIGITS_CHAR) begin
        hdr_abort = 1'b1;
      end
      if (state == tmc_pkg::ST_LEN && rx_data != exp_char) begin
        hdr_abort = 1'b1;
      end
    end
  end

  assign rec_ok = !bad && zero_seen && (rx_sum == data_sum);

  always_comb begin
    case (cmd_code)
      tmc_pkg::CMD_UPLOAD: legal = passfail_enable && slot_ok;
      tmc_pkg::CMD_DOWNLOAD: legal = passfail_enable && slot_ok;
      tmc_pkg::CMD_SET_MAX: legal = passfail_enable && slot_ok &&
          template_mode == tmc_pkg::MODE_NORMAL &&
          cmd_arg[6:0] != min_template;
      tmc_pkg::CMD_SET_MIN: legal = passfail_enable && slot_ok &&
          template_mode == tmc_pkg::MODE_NORMAL &&
          cmd_arg[6:0] != max_template;
      tmc_pkg::CMD_SET_MODE: legal = cmd_arg <= 8'h01;
      tmc_pkg::CMD_SET_SOURCE: legal = (template_mode == tmc_pkg::MODE_AUTO) ?
          (cmd_arg == 8'h01 || cmd_arg == 8'h02) : (cmd_arg <= 8'h02);
      tmc_pkg::CMD_SET_MEAS_CH: legal = cmd_arg == 8'h01 || cmd_arg == 8'h02;
      tmc_pkg::CMD_RUN: legal = 1'b1;
      tmc_pkg::CMD_STOP: legal = 1'b1;
      tmc_pkg::CMD_DUTY: legal = 1'b1;
      default: legal = 1'b0;
    endcase
  end

  // Transfer sequencer
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= tmc_pkg::ST_IDLE;
      cnt <= 10'h000;
      slot_sel <= tmc_pkg::MAX_SEL_RST;
    end else begin
      case (state)
        tmc_pkg::ST_IDLE: begin
          cnt <= 10'h000;
          if (cmd_take && legal) begin
            if (cmd_code == tmc_pkg::CMD_UPLOAD) begin
              slot_sel <= cmd_arg[6:0];
              state <= tmc_pkg::ST_HASH;
            end
            if (cmd_code == tmc_pkg::CMD_DOWNLOAD) begin
              slot_sel <= cmd_arg[6:0];
              state <= tmc_pkg::ST_SEND_HDR;
            end
          end
        end
        tmc_pkg::ST_HASH: begin
          if (hdr_abort) begin
            state <= tmc_pkg::ST_IDLE;
          end else if (rx_fire) begin
            state <= tmc_pkg::ST_NDIG;
          end
        end
        tmc_pkg::ST_NDIG: begin
          if (hdr_abort) begin
            state <= tmc_pkg::ST_IDLE;
          end else if (rx_fire) begin
            state <= tmc_pkg::ST_LEN;
          end
        end
        tmc_pkg::ST_LEN: begin
          if (hdr_abort) begin
            state <= tmc_pkg::ST_IDLE;
          end else if (rx_fire) begin
            cnt <= (cnt == tmc_pkg::LEN_LAST) ? 10'h000 : cnt + 10'h001;
            if (cnt == tmc_pkg::LEN_LAST) begin
              state <= tmc_pkg::ST_LOAD;
            end
          end
        end
        tmc_pkg::ST_LOAD: begin
          if (rx_fire) begin
            if (cnt == tmc_pkg::REC_LAST) begin
              state <= tmc_pkg::ST_CHECK;
            end else begin
              cnt <= cnt + 10'h001;
            end
          end
        end
        tmc_pkg::ST_CHECK: begin
          cnt <= 10'h000;
          state <= rec_ok ? tmc_pkg::ST_COPY : tmc_pkg::ST_IDLE;
        end
        tmc_pkg::ST_COPY: begin
          if (cnt == tmc_pkg::REC_LAST) begin
            state <= tmc_pkg::ST_IDLE;
          end else begin
            cnt <= cnt + 10'h001;
          end
        end
        tmc_pkg::ST_SEND_HDR: begin
          if (tx_load) begin
            cnt <= (cnt[2:0] == tmc_pkg::HDR_LAST) ? 10'h000 : cnt + 10'h001;
            if (cnt[2:0] == tmc_pkg::HDR_LAST) begin
              state <= tmc_pkg::ST_SEND_BODY;
            end
          end
        end
        tmc_pkg::ST_SEND_BODY: begin
          if (tx_load) begin
            if (cnt == tmc_pkg::REC_LAST) begin
              state <= tmc_pkg::ST_DRAIN;
            end else begin
              cnt <= cnt + 10'h001;
            end
          end
        end
        tmc_pkg::ST_DRAIN: begin
          if (tx_ready) begin
            state <= tmc_pkg::ST_IDLE;
          end
        end
        default: state <= tmc_pkg::ST_IDLE;
      endcase
    end
  end

  // Field checks while the payload streams in
  always_ff @(posedge clock) begin
    if (rst || state == tmc_pkg::ST_IDLE) begin
      bad <= 1'b0;
      zero_seen <= 1'b0;
      hold <= 8'h00;
      rx_sum <= 32'h00000000;
      data_sum <= 32'h00000000;
    end else if (state == tmc_pkg::ST_LOAD && rx_fire) begin
      hold <= rx_data;
      if (cnt == tmc_pkg::OFS_TYPE && rx_data != tmc_pkg::PACKAGE_TYPE) begin
        bad <= 1'b1;
      end
      if (cnt == tmc_pkg::OFS_SLOT &&
          (rx_data < tmc_pkg::SLOT_MIN || rx_data > tmc_pkg::SLOT_MAX)) begin
        bad <= 1'b1;
      end
      if (cnt == tmc_pkg::OFS_POS_LO && ($signed(pair) < $signed(tmc_pkg::POS_MIN) ||
          $signed(pair) > $signed(tmc_pkg::POS_MAX))) begin
        bad <= 1'b1;
      end
      if (cnt >= tmc_pkg::OFS_LABEL && cnt <= tmc_pkg::OFS_LABEL_END &&
          rx_data == 8'h00) begin
        zero_seen <= 1'b1;
      end
      // Byte at OFS_RSV is accepted with any value
      if (cnt >= tmc_pkg::OFS_SUM && cnt <= tmc_pkg::OFS_SUM_END) begin
        rx_sum <= {rx_sum[23:0], rx_data};
      end
      if (cnt >= tmc_pkg::OFS_DATA) begin
        data_sum <= data_sum + {24'h000000, rx_data};
        if (cnt[0] && ($signed(pair) < $signed(tmc_pkg::POINT_MIN) ||
            $signed(pair) > $signed(tmc_pkg::POINT_MAX))) begin
          bad <= 1'b1;
        end
      end
    end
  end

  // Staging keeps a failed upload from touching the stored slot
  always_ff @(posedge clock) begin
    if (state == tmc_pkg::ST_LOAD && rx_fire) begin
      stage[cnt] <= rx_data;
    end
  end

  always_ff @(posedge clock) begin
    if (state == tmc_pkg::ST_COPY) begin
      store_mem[mem_addr] <= stage[cnt];
    end
  end

  // Record output stream
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
    end else begin
      case (state)
        tmc_pkg::ST_SEND_HDR: begin
          if (tx_load) begin
            tx_valid <= 1'b1;
            case (cnt[2:0])
              3'h0: tx_data <= tmc_pkg::HASH_CHAR;
              3'h1: tx_data <= tmc_pkg::LEN_DIGITS_CHAR;
              3'h2: tx_data <= tmc_pkg::LEN_CHAR_0;
              3'h3: tx_data <= tmc_pkg::LEN_CHAR_1;
              default: tx_data <= tmc_pkg::LEN_CHAR_2;
            endcase
          end
        end
        tmc_pkg::ST_SEND_BODY: begin
          if (tx_load) begin
            tx_valid <= 1'b1;
            tx_data <= store_mem[mem_addr];
          end
        end
        tmc_pkg::ST_DRAIN: begin
          if (tx_ready) begin
            tx_valid <= 1'b0;
          end
        end
        default: tx_valid <= 1'b0;
      endcase
    end
  end

  // Completion and refusal pulses
  always_ff @(posedge clock) begin
    if (rst) begin
      cmd_done <= 1'b0;
      cmd_refused <= 1'b0;
      upload_stored <= 1'b0;
      upload_discarded <= 1'b0;
    end else begin
      upload_stored <= state == tmc_pkg::ST_COPY && cnt == tmc_pkg::REC_LAST;
      upload_discarded <= hdr_abort || (state == tmc_pkg::ST_CHECK && !rec_ok);
      cmd_refused <= (cmd_take && !legal) || hdr_abort ||
                     (state == tmc_pkg::ST_CHECK && !rec_ok);
      cmd_done <= (cmd_take && legal && cmd_code != tmc_pkg::CMD_UPLOAD &&
                   cmd_code != tmc_pkg::CMD_DOWNLOAD && cmd_code != tmc_pkg::CMD_DUTY) ||
                  (state == tmc_pkg::ST_COPY && cnt == tmc_pkg::REC_LAST) ||
                  (state == tmc_pkg::ST_DRAIN && tx_ready) || div_bus.done;
    end
  end

  // Template selection settings
  always_ff @(posedge clock) begin
    if (rst) begin
      max_template <= tmc_pkg::MAX_SEL_RST;
      min_template <= tmc_pkg::MIN_SEL_RST;
      template_mode <= tmc_pkg::MODE_NORMAL;
      auto_source_channel <= tmc_pkg::AUTO_CH_RST;
      normal_source <= tmc_pkg::SRC_STORED;
      measure_channel_select <= tmc_pkg::MEAS_CH_RST;
    end else if (cmd_take && legal) begin
      case (cmd_code)
        tmc_pkg::CMD_SET_MAX: max_template <= cmd_arg[6:0];
        tmc_pkg::CMD_SET_MIN: min_template <= cmd_arg[6:0];
        tmc_pkg::CMD_SET_MODE: template_mode <= cmd_arg[0];
        tmc_pkg::CMD_SET_SOURCE: begin
          if (template_mode == tmc_pkg::MODE_AUTO) begin
            auto_source_channel <= cmd_arg[1:0];
          end else begin
            normal_source <= tmc_pkg::tmc_src_type'(cmd_arg[1:0]);
          end
        end
        tmc_pkg::CMD_SET_MEAS_CH: measure_channel_select <= cmd_arg[1:0];
        default: max_template <= max_template;
      endcase
    end
  end

  // Level measurements follow the selected channel continuously
  always_ff @(posedge clock) begin
    if (rst) begin
      amplitude <= 16'h0000;
      peak_to_peak <= 16'h0000;
    end else begin
      amplitude <= ch_high[ch_idx] - ch_low[ch_idx];
      peak_to_peak <= ch_max[ch_idx] - ch_min[ch_idx];
    end
  end

  assign div_bus.start = cmd_take && cmd_code == tmc_pkg::CMD_DUTY;
  assign div_bus.dividend = 23'(ch_pos_width[ch_idx] * tmc_pkg::PERCENT);
  assign div_bus.divisor = ch_period[ch_idx];

  // Clamp keeps a width beyond the period or a zero period in range
  always_ff @(posedge clock) begin
    if (rst) begin
      duty_ratio <= tmc_pkg::DUTY_MIN;
      duty_ready <= 1'b0;
    end else begin
      duty_ready <= div_bus.done;
      if (div_bus.done) begin
        if (div_bus.quotient < 23'(tmc_pkg::DUTY_MIN)) begin
          duty_ratio <= tmc_pkg::DUTY_MIN;
        end else if (div_bus.quotient > 23'(tmc_pkg::DUTY_MAX)) begin
          duty_ratio <= tmc_pkg::DUTY_MAX;
        end else begin
          duty_ratio <= div_bus.quotient[6:0];
        end
      end
    end
  end

  // Run and stop of acquisition
  always_ff @(posedge clock) begin
    if (rst) begin
      running <= tmc_pkg::RUN_RST;
      acquire_start <= 1'b0;
    end else begin
      if (cmd_take && cmd_code == tmc_pkg::CMD_RUN) begin
        running <= 1'b1;
      end else if (cmd_take && cmd_code == tmc_pkg::CMD_STOP) begin
        running <= 1'b0;
      end
      acquire_start <= running && trigger_qualified;
    end
  end
endmodule
`default_nettype wire

// file: verification/tb.sv
// Self-checking bench for the template command block.
// Assumes the host model serves the record streams.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock, rst, cmd_valid, cmd_ready, cmd_done, cmd_refused, passfail_enable;
  tmc_pkg::tmc_cmd_type cmd_code;
  tmc_pkg::tmc_src_type normal_source;
  logic [7:0] cmd_arg, rx_data, tx_data;
  logic rx_valid, rx_ready, tx_valid, tx_ready, upload_stored, upload_discarded;
  logic [6:0] max_template, min_template, duty_ratio;
  logic template_mode, duty_ready, trigger_qualified, running, acquire_start;
  logic [1:0] auto_source_channel, measure_channel_select;
  logic [1:0][15:0] ch_high, ch_low, ch_max, ch_min, ch_pos_width, ch_period;
  logic [15:0] amplitude, peak_to_peak;
  logic [1:0] r;
  int num_errors, tests_run, cycles, bad;
  int duty_tab [4][3] = '{'{30, 100, 30}, '{0, 100, 1}, '{250, 100, 99}, '{2, 3, 66}};
  tmc_template_cmd i_dut (.*);
  tmc_host_model i_host (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic issue(input tmc_pkg::tmc_cmd_type c, input logic [7:0] a);
    int w;
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_arg <= a;
    w = 0;
    do begin
      @(posedge clock);
      w++;
    end while (!cmd_ready && w < 50);
    cmd_valid <= 1'b0;
  endtask
  task automatic finish(output logic [1:0] res);
    int w;
    w = 0;
    res = 2'b00;
    while (res == 2'b00 && w < 1500) begin
      @(posedge clock);
      w++;
      res = {cmd_refused, cmd_done};
    end
  endtask
  task automatic run_cmd(input tmc_pkg::tmc_cmd_type c, input logic [7:0] a, input logic [1:0] e);
    issue(c, a);
    finish(r);
    chk(r, e);
  endtask
  task automatic upload(input logic [7:0] slot, input int fault, input logic [1:0] e);
    i_host.build(slot, fault);
    issue(tmc_pkg::CMD_UPLOAD, slot);
    fork
      i_host.send();
      begin
        finish(r);
        chk({upload_discarded, upload_stored}, e);
      end
    join
    chk(r, e);
  endtask
  task automatic download(input logic [7:0] slot);
    issue(tmc_pkg::CMD_DOWNLOAD, slot);
    i_host.recv(bad);
    finish(r);
    chk(bad, 0);
    chk(r, 2'b01);
  endtask
  task automatic test_done();
    $display("errors=%0d checks=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Hang guard, far above the few thousand cycles needed
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end
  initial begin
    {rst, cmd_valid, passfail_enable, trigger_qualified, cmd_arg} = {4'h8, 8'h00};
    cmd_code = tmc_pkg::CMD_RUN;
    {ch_high, ch_low} = {16'h0300, 16'h0100, 16'h0080, 16'h0040};
    {ch_max, ch_min} = {16'h0400, 16'h0120, 16'hffc0, 16'h0010};
    {ch_pos_width, ch_period} = {16'h0001, 16'h0001, 16'h0002, 16'h0002};
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    // Levels lag one cycle behind reset release
    repeat (2) @(posedge clock);
    chk({max_template, min_template, template_mode}, {7'h01, 7'h02, 1'b0});
    chk({measure_channel_select, running}, {2'h1, 1'b1});
    chk({amplitude, peak_to_peak}, {16'h00c0, 16'h0110});
    run_cmd(tmc_pkg::CMD_SET_MAX, 8'h05, 2'b10);
    passfail_enable <= 1'b1;
    run_cmd(tmc_pkg::CMD_SET_MAX, 8'h05, 2'b01);
    chk(max_template, 7'h05);
    run_cmd(tmc_pkg::CMD_SET_MIN, 8'h05, 2'b10);
    run_cmd(tmc_pkg::CMD_SET_MIN, 8'h64, 2'b01);
    chk(min_template, 7'h64);
    run_cmd(tmc_pkg::CMD_SET_MAX, 8'h65, 2'b10);
    run_cmd(tmc_pkg::CMD_SET_MODE, 8'h01, 2'b01);
    chk(template_mode, 1'b1);
    run_cmd(tmc_pkg::CMD_SET_SOURCE, 8'h00, 2'b10);
    run_cmd(tmc_pkg::CMD_SET_SOURCE, 8'h02, 2'b01);
    chk(auto_source_channel, 2'h2);
    run_cmd(tmc_pkg::CMD_SET_MAX, 8'h03, 2'b10);
    run_cmd(tmc_pkg::CMD_SET_MODE, 8'h02, 2'b10);
    run_cmd(tmc_pkg::CMD_SET_MODE, 8'h00, 2'b01);
    run_cmd(tmc_pkg::CMD_SET_SOURCE, 8'h02, 2'b01);
    chk(normal_source, tmc_pkg::SRC_REFERENCE_WAVE_B);
    run_cmd(tmc_pkg::CMD_SET_MEAS_CH, 8'h03, 2'b10);
    run_cmd(tmc_pkg::CMD_SET_MEAS_CH, 8'h02, 2'b01);
    @(posedge clock);
    chk({amplitude, peak_to_peak}, {16'h0280, 16'h0440});
    foreach (duty_tab[i]) begin
      ch_pos_width[1] <= 16'(duty_tab[i][0]);
      ch_period[1] <= 16'(duty_tab[i][1]);
      run_cmd(tmc_pkg::CMD_DUTY, 8'h00, 2'b01);
      chk({duty_ready, duty_ratio}, {1'b1, 7'(duty_tab[i][2])});
    end
    trigger_qualified <= 1'b1;
    repeat (2) @(posedge clock);
    chk(acquire_start, 1'b1);
    run_cmd(tmc_pkg::CMD_STOP, 8'h00, 2'b01);
    repeat (2) @(posedge clock);
    chk({running, acquire_start}, 2'b00);
    run_cmd(tmc_pkg::CMD_RUN, 8'h00, 2'b01);
    @(posedge clock);
    chk(acquire_start, 1'b1);
    trigger_qualified <= 1'b0;
    upload(8'h07, 0, 2'b01);
    download(8'h07);
    upload(8'h07, 1, 2'b10);
    i_host.build(8'h07, 0);
    download(8'h07);
    upload(8'h09, 2, 2'b10);
    test_done();
  end
endmodule
`default_nettype wire

// file: verification/tmc_host_model.sv
// Host side model: builds and streams upload records, takes downloads.
// Assumes the bench calls its tasks one transfer at a time.
`timescale 1ns/1ps
`default_nettype none
module tmc_host_model (
  input wire logic clock,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic tx_ready
);
  logic [7:0] rec [0:552];
  logic [31:0] sum;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
  end
  // Fault 1 spoils the sum, fault 2 the digit count
  task automatic build(input logic [7:0] slot, input int fault);
    sum = 32'h0;
    foreach (rec[i]) rec[i] = 8'h00;
    rec[0] = 8'h23;
    rec[1] = (fault == 2) ? 8'h34 : 8'h33;
    {rec[2], rec[3], rec[4]} = {8'h35, 8'h34, 8'h38};
    rec[5] = 8'h03;
    rec[6] = slot;
    {rec[7], rec[8]} = 16'hffce;
    rec[9] = 8'h54;
    for (int p = 0; p < 250; p++) begin
      {rec[53+2*p], rec[54+2*p]} = 16'(p % 201 - 100);
      sum += rec[53+2*p] + rec[54+2*p];
    end
    if (fault == 1) sum++;
    {rec[49], rec[50], rec[51], rec[52]} = sum;
  endtask
  task automatic send();
    int w;
    for (int n = 0; n < 553; n++) begin
      rx_valid <= 1'b1;
      rx_data <= rec[n];
      w = 0;
      do begin
        @(posedge clock);
        w++;
      end while (!rx_ready && w < 20);
      if (!rx_ready) break;
    end
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
  endtask
  // Stalls every fourth cycle to act as a slow reader
  task automatic recv(output int bad);
    int n;
    int w;
    bad = 0;
    n = 0;
    w = 0;
    while (n < 553 && w < 3000) begin
      tx_ready <= (w % 4 != 3);
      @(posedge clock);
      w++;
      if (tx_valid && tx_ready) begin
        if (tx_data !== rec[n]) bad++;
        n++;
      end
    end
    tx_ready <= 1'b0;
    if (n < 553) bad++;
  endtask
endmodule
`default_nettype wire

// file: verification/tmc_template_cmd_assertions.sv
// Port checker for the template command block.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module tmc_template_cmd_assertions (
  input wire logic clock,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire tmc_pkg::tmc_cmd_type cmd_code,
  input wire logic [7:0] cmd_arg,
  input wire logic cmd_ready,
  input wire logic cmd_refused,
  input wire logic passfail_enable,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic upload_stored,
  input wire logic upload_discarded,
  input wire logic [6:0] max_template,
  input wire logic [6:0] min_template,
  input wire logic template_mode,
  input wire logic [1:0] measure_channel_select,
  input wire logic [6:0] duty_ratio,
  input wire logic duty_ready,
  input wire logic trigger_qualified,
  input wire logic running,
  input wire logic acquire_start
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic tk;
  logic arg_ok;
  logic fire;
  assign tk = cmd_valid && cmd_ready && passfail_enable;
  assign arg_ok = cmd_arg >= 8'h01 && cmd_arg <= 8'h64;
  assign fire = running && trigger_qualified;
  property p_set_max;
    tk && cmd_code == tmc_pkg::CMD_SET_MAX && arg_ok && !template_mode
      && cmd_arg[6:0] != min_template |=> max_template == $past(cmd_arg[6:0]);
  endproperty
  a_set_max: assert property (p_set_max) else $error("upper slot not taken");
  property p_set_min;
    tk && cmd_code == tmc_pkg::CMD_SET_MIN && arg_ok && !template_mode
      && cmd_arg[6:0] != max_template |=> min_template == $past(cmd_arg[6:0]);
  endproperty
  a_set_min: assert property (p_set_min) else $error("lower slot not taken");
  property p_distinct;
    max_template != min_template;
  endproperty
  a_distinct: assert property (p_distinct) else $error("slot on both bounds");
  property p_auto;
    tk && template_mode && (cmd_code == tmc_pkg::CMD_SET_MAX || cmd_code == tmc_pkg::CMD_SET_MIN)
      |=> cmd_refused && $stable(max_template) && $stable(min_template);
  endproperty
  a_auto: assert property (p_auto) else $error("bound set in auto mode");
  property p_mode;
    cmd_valid && cmd_ready && cmd_code == tmc_pkg::CMD_SET_MODE && cmd_arg <= 8'h01
      |=> template_mode == $past(cmd_arg[0]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode not set");
  property p_rst;
    $fell(rst) |-> measure_channel_select == 2'h1 && running && !template_mode;
  endproperty
  a_rst: assert property (p_rst) else $error("bad value after reset");
  property p_duty;
    duty_ready |-> duty_ratio >= 7'h01 && duty_ratio <= 7'h63;
  endproperty
  a_duty: assert property (p_duty) else $error("duty out of range");
  property p_acq;
    !$past(rst) |-> acquire_start == $past(fire);
  endproperty
  a_acq: assert property (p_acq) else $error("acquire start wrong");
  property p_dl;
    tk && cmd_code == tmc_pkg::CMD_DOWNLOAD && arg_ok
      |-> ##2 tx_valid && tx_data == tmc_pkg::HASH_CHAR;
  endproperty
  a_dl: assert property (p_dl) else $error("record start missing");
  c_store: cover property (upload_stored);
  c_disc: cover property (upload_discarded);
  c_duty: cover property (duty_ready);
endmodule
bind tmc_template_cmd tmc_template_cmd_assertions i_chk (.*);
`default_nettype wire
